// ### src/ext_state_pkg.sv
// Constants and types shared by the extended state save control block
package ext_state_pkg;

  // Register port offsets (byte addresses)
  localparam logic [7:0] PRIMARY_CTRL_OFS = 8'h00;
  localparam logic [7:0] FOURTH_CTRL_OFS  = 8'h04;
  localparam logic [7:0] FEAT_EN_LO_OFS   = 8'h08;
  localparam logic [7:0] FEAT_EN_HI_OFS   = 8'h0c;
  localparam logic [7:0] STATUS_OFS       = 8'h10;
  localparam logic [7:0] NM_COUNT_OFS     = 8'h14;

  // Field positions
  localparam int LAZY_TRAP_BIT   = 3;
  localparam int OS_EXT_EN_BIT   = 18;
  localparam int QUERY_XSUP_BIT  = 26;
  localparam int QUERY_OSEN_BIT  = 27;

  // State components: 0 floating point, 1 vector, 2 wide extended
  localparam int NUM_COMP  = 3;
  localparam int NUM_WORDS = 4;
  localparam logic [2:0] SUPPORTED_MASK = 3'h7;
  localparam logic [2:0] FEAT_EN_RESET  = 3'h1;

  // Save area layout in bytes
  localparam logic [31:0] LEGACY_SIZE  = 32'h0000_0200;
  localparam logic [31:0] HEADER_OFS   = 32'h0000_0200;
  localparam logic [31:0] HEADER_SIZE  = 32'h0000_0040;
  localparam logic [31:0] HDR_ZERO0    = 32'h0000_0208;
  localparam logic [31:0] HDR_ZERO1    = 32'h0000_0210;
  localparam logic [31:0] COMP0_OFS    = 32'h0000_0020;
  localparam logic [31:0] COMP1_OFS    = 32'h0000_00a0;
  localparam logic [31:0] COMP2_OFS    = 32'h0000_0240;
  localparam logic [31:0] COMP_SIZE    = 32'h0000_0020;
  localparam logic [31:0] AREA_SIZE    = 32'h0000_0260;
  localparam logic [31:0] AREA_ALIGN_M = 32'h0000_003f;

  // Query leaves
  localparam logic [31:0] LEAF_BASIC   = 32'h0000_0001;
  localparam logic [31:0] LEAF_XSTATE  = 32'h0000_000d;

  // Hardware init values used when a header bit is clear
  localparam logic [63:0] COMP_INIT     = 64'h0;
  localparam logic [63:0] VEC_CTRL_INIT = 64'h0;

  // Instruction classes presented by the decoder
  typedef enum logic [3:0] {
    ic_general,
    ic_fp,
    ic_vector,
    ic_wide,
    ic_checksum,
    ic_popcount,
    ic_mov_ctrl,
    ic_trap_clear,
    ic_task_switch,
    ic_feat_read,
    ic_feat_write,
    ic_save,
    ic_restore,
    ic_query
  } instr_class_e;

endpackage

// ### src/extended_state_save_control.sv
// Lazy trap, feature enable and mask driven save and restore engine
//
// Contract
// - Trap state-touching instructions while lazy flag set; here save and restore trap only if the mask selects component 0 or 1.
// - No trap for tasks never touching state.
// - Checksum and population count never trap.
// - Move to primary control sets lazy flag.
// - Hardware task switch sets lazy flag.
// - Area is legacy, header, component regions.
// - Leaf 0dh reports components, offsets and sizes.
// - Basic leaf bit 26 reports save support.
// - Basic leaf bit 27 mirrors OS enable.
// - Fourth control bit 18 enables extended state.
// - Feature enable readable anywhere, writable ring 0.
// - Restore reloads only masked components.
// - Save writes components selected by mask.
// - Save sets header bit of written component.
// - Header bitmap order matches feature enable.
// - Header bitmap at 0, next words zero.
// - Header bit chooses load or hardware init.
// - Clear header bit ignores region contents.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module extended_state_save_control
  import ext_state_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata,
  input  wire logic         instr_valid,
  input  wire instr_class_e instr_class,
  input  wire logic [1:0]   instr_ring,
  input  wire logic [63:0]  instr_data,
  input  wire logic [31:0]  instr_eax,
  input  wire logic [31:0]  instr_edx,
  input  wire logic [31:0]  instr_ecx,
  output logic              instr_ready,
  output logic              instr_done,
  output logic      [31:0]  res_a,
  output logic      [31:0]  res_b,
  output logic      [31:0]  res_c,
  output logic      [31:0]  res_d,
  output logic              device_unavailable_fault,
  output logic              privilege_fault,
  output logic              invalid_opcode_fault,
  output logic              lazy_trap_flag,
  output logic      [31:0]  mem_addr,
  output logic      [63:0]  mem_wdata,
  output logic              mem_wr,
  output logic              mem_rd,
  input  wire logic [63:0]  mem_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef enum logic [3:0] {
    st_idle,
    st_sv_hdr,
    st_sv_wait,
    st_sv_cap,
    st_sv_word,
    st_sv_hdrw,
    st_sv_zero0,
    st_sv_zero1,
    st_rs_hdr,
    st_rs_wait,
    st_rs_cap,
    st_rs_word,
    st_rl_wait,
    st_rs_load
  } eng_e;

  typedef struct packed {
    logic                                  lazy;
    logic                                  os_en;
    logic [2:0]                            fen;
    logic [NUM_COMP-1:0][NUM_WORDS-1:0][63:0] comp;
    eng_e                                  st;
    logic [1:0]                            c;
    logic [1:0]                            w;
    logic [2:0]                            rfbm;
    logic [2:0]                            hdr;
    logic [31:0]                           base;
    logic [31:0]                           maddr;
    logic [63:0]                           mwdata;
    logic                                  mwr;
    logic                                  mrd;
    logic [31:0]                           rdata;
    logic [31:0]                           ra;
    logic [31:0]                           rb;
    logic [31:0]                           rc;
    logic [31:0]                           rd;
    logic                                  done;
    logic                                  nm;
    logic                                  gp;
    logic                                  ud;
    logic [15:0]                           nm_cnt;
  } state_s;

  state_s state_reg;
  state_s state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte offset of a component region within the save area
  function automatic logic [31:0] comp_ofs(input logic [1:0] c);
    unique case (c)
      2'h0:    comp_ofs = COMP0_OFS;
      2'h1:    comp_ofs = COMP1_OFS;
      default: comp_ofs = COMP2_OFS;
    endcase
  endfunction

  // Byte address of one 64-bit word of a component region
  function automatic logic [31:0] word_addr(input logic [31:0] base,
                                            input logic [1:0]  c,
                                            input logic [1:0]  w);
    word_addr = base + comp_ofs(c) + {27'h0, w, 3'h0};
  endfunction

  // Next component and word; top bit marks the walk as finished
  function automatic logic [4:0] step(input logic [1:0] c,
                                      input logic [1:0] w,
                                      input logic       whole);
    if (whole || w == 2'(NUM_WORDS - 1))
    begin
      if (c == 2'(NUM_COMP - 1))
        step = {1'b1, 4'h0};
      else
        step = {1'b0, c + 2'h1, 2'h0};
    end
    else
      step = {1'b0, c, w + 2'h1};
  endfunction

  // Component selected by a state-touching instruction class
  function automatic logic [1:0] class_comp(input instr_class_e k);
    unique case (k)
      ic_fp:     class_comp = 2'h0;
      ic_vector: class_comp = 2'h1;
      default:   class_comp = 2'h2;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [4:0]  nx;
    logic [2:0]  msk;
    logic [2:0]  nfen;
    logic [1:0]  k;
    nx   = 5'h0;
    msk  = instr_eax[2:0] & state_reg.fen;
    nfen = instr_eax[2:0];
    k    = class_comp(instr_class);
    state_next        = state_reg;
    state_next.done   = 1'b0;
    state_next.nm     = 1'b0;
    state_next.gp     = 1'b0;
    state_next.ud     = 1'b0;
    state_next.mwr    = 1'b0;
    state_next.mrd    = 1'b0;
    state_next.rdata  = 32'h0;

    // Register port reads, data stand one cycle later
    if (reg_rd)
    begin
      unique case (reg_addr)
        PRIMARY_CTRL_OFS: state_next.rdata[LAZY_TRAP_BIT] = state_reg.lazy;
        FOURTH_CTRL_OFS:  state_next.rdata[OS_EXT_EN_BIT] = state_reg.os_en;
        FEAT_EN_LO_OFS:   state_next.rdata = {29'h0, state_reg.fen};
        STATUS_OFS:       state_next.rdata = {31'h0, state_reg.st != st_idle};
        NM_COUNT_OFS:     state_next.rdata = {16'h0, state_reg.nm_cnt};
        default:          state_next.rdata = 32'h0;
      endcase
    end

    // Register port writes to the control registers
    if (reg_wr && reg_addr == PRIMARY_CTRL_OFS)
      state_next.lazy = reg_wdata[LAZY_TRAP_BIT];
    if (reg_wr && reg_addr == FOURTH_CTRL_OFS)
      state_next.os_en = reg_wdata[OS_EXT_EN_BIT];

    // Instruction issue, one at a time while the engine is idle
    if (instr_valid && state_reg.st == st_idle)
    begin
      state_next.done = 1'b1;
      state_next.ra   = 32'h0;
      state_next.rb   = 32'h0;
      state_next.rc   = 32'h0;
      state_next.rd   = 32'h0;
      unique case (instr_class)
        ic_fp, ic_vector, ic_wide:
        begin
          // Trap, or invalid opcode for the wide class with feature bit 2 clear, before touching state; old word returned otherwise
          if (state_reg.lazy)
            state_next.nm = 1'b1;
          else if (k == 2'h2 && !state_reg.fen[2])
            state_next.ud = 1'b1;
          else
          begin
            state_next.ra = state_reg.comp[k][instr_ecx[1:0]][31:0];
            state_next.rb = state_reg.comp[k][instr_ecx[1:0]][63:32];
            state_next.comp[k][instr_ecx[1:0]] = instr_data;
          end
        end
        ic_general, ic_checksum, ic_popcount:
          state_next.done = 1'b1;
        ic_mov_ctrl:
        begin
          if (instr_ring != 2'h0)
            state_next.gp = 1'b1;
          else
            state_next.lazy = instr_data[LAZY_TRAP_BIT];
        end
        ic_trap_clear:
        begin
          if (instr_ring != 2'h0)
            state_next.gp = 1'b1;
          else
            state_next.lazy = 1'b0;
        end
        ic_task_switch:
          state_next.lazy = 1'b1;
        ic_feat_read:
        begin
          if (!state_reg.os_en)
            state_next.ud = 1'b1;
          else
            state_next.ra = {29'h0, state_reg.fen};
        end
        ic_feat_write:
        begin
          if (!state_reg.os_en)
            state_next.ud = 1'b1;
          else if (instr_ring != 2'h0)
            state_next.gp = 1'b1;
          else if (!nfen[0] || instr_edx != 32'h0 ||
                   instr_eax[31:3] != 29'h0 || (nfen & ~SUPPORTED_MASK) != 3'h0)
            state_next.gp = 1'b1;
          else
            state_next.fen = nfen;
        end
        ic_save, ic_restore:
        begin
          if (!state_reg.os_en)
            state_next.ud = 1'b1;
          else if (state_reg.lazy && msk[1:0] != 2'h0)
            state_next.nm = 1'b1;
          else if ((instr_data[31:0] & AREA_ALIGN_M) != 32'h0)
            state_next.gp = 1'b1;
          else
          begin
            state_next.done = 1'b0;
            state_next.rfbm = msk;
            state_next.base = instr_data[31:0];
            state_next.c    = 2'h0;
            state_next.w    = 2'h0;
            state_next.st   = (instr_class == ic_save) ? st_sv_hdr : st_rs_hdr;
          end
        end
        ic_query:
        begin
          if (instr_eax == LEAF_BASIC)
          begin
            state_next.rc[QUERY_XSUP_BIT] = 1'b1;
            state_next.rc[QUERY_OSEN_BIT] = state_reg.os_en;
          end
          else if (instr_eax == LEAF_XSTATE && instr_ecx == 32'h0)
          begin
            state_next.ra = {29'h0, SUPPORTED_MASK};
            state_next.rb = state_reg.fen[2] ? AREA_SIZE : LEGACY_SIZE + HEADER_SIZE;
            state_next.rc = AREA_SIZE;
          end
          else if (instr_eax == LEAF_XSTATE && instr_ecx == 32'h2)
          begin
            state_next.ra = COMP_SIZE;
            state_next.rb = COMP2_OFS;
          end
        end
        default:
          state_next.ud = 1'b1;
      endcase
      // A faulting instruction never reports completion
      if (state_next.nm || state_next.gp || state_next.ud)
        state_next.done = 1'b0;
    end

    // Save and restore engine
    unique case (state_reg.st)
      st_idle:
        state_next.st = state_next.st;
      st_sv_hdr, st_rs_hdr:
      begin
        // Fetch the header bitmap word
        state_next.mrd   = 1'b1;
        state_next.maddr = state_reg.base + HEADER_OFS;
        state_next.st    = (state_reg.st == st_sv_hdr) ? st_sv_wait : st_rs_wait;
      end
      st_sv_wait:
        state_next.st = st_sv_cap;
      st_rs_wait:
        state_next.st = st_rs_cap;
      st_sv_cap:
      begin
        state_next.hdr = mem_rdata[2:0];
        state_next.st  = st_sv_word;
      end
      st_rs_cap:
      begin
        state_next.hdr = mem_rdata[2:0];
        state_next.st  = st_rs_word;
      end
      st_sv_word:
      begin
        // Store each word of every selected component
        if (state_reg.rfbm[state_reg.c])
        begin
          state_next.mwr    = 1'b1;
          state_next.maddr  = word_addr(state_reg.base, state_reg.c, state_reg.w);
          state_next.mwdata = state_reg.comp[state_reg.c][state_reg.w];
        end
        nx = step(state_reg.c, state_reg.w, !state_reg.rfbm[state_reg.c]);
        state_next.c  = nx[3:2];
        state_next.w  = nx[1:0];
        state_next.st = nx[4] ? st_sv_hdrw : st_sv_word;
      end
      st_sv_hdrw:
      begin
        state_next.mwr    = 1'b1;
        state_next.maddr  = state_reg.base + HEADER_OFS;
        state_next.mwdata = {61'h0, state_reg.hdr | state_reg.rfbm};
        state_next.st     = st_sv_zero0;
      end
      st_sv_zero0:
      begin
        state_next.mwr    = 1'b1;
        state_next.maddr  = state_reg.base + HDR_ZERO0;
        state_next.mwdata = 64'h0;
        state_next.st     = st_sv_zero1;
      end
      st_sv_zero1:
      begin
        state_next.mwr    = 1'b1;
        state_next.maddr  = state_reg.base + HDR_ZERO1;
        state_next.mwdata = 64'h0;
        state_next.st     = st_idle;
        state_next.done   = 1'b1;
      end
      st_rs_word:
      begin
        if (state_reg.rfbm[state_reg.c] && state_reg.hdr[state_reg.c])
        begin
          // Header bit set: load the word from memory
          state_next.mrd   = 1'b1;
          state_next.maddr = word_addr(state_reg.base, state_reg.c, state_reg.w);
          state_next.st    = st_rl_wait;
        end
        else
        begin
          // Header bit clear: hardware init, memory never read
          if (state_reg.rfbm[state_reg.c])
          begin
            for (int i = 0; i < NUM_WORDS; i++)
              state_next.comp[state_reg.c][i] = COMP_INIT;
            if (state_reg.c == 2'h1)
              state_next.comp[1][0] = VEC_CTRL_INIT;
          end
          nx = step(state_reg.c, state_reg.w, 1'b1);
          state_next.c    = nx[3:2];
          state_next.w    = nx[1:0];
          state_next.st   = nx[4] ? st_idle : st_rs_word;
          state_next.done = nx[4];
        end
      end
      st_rl_wait:
        state_next.st = st_rs_load;
      st_rs_load:
      begin
        state_next.comp[state_reg.c][state_reg.w] = mem_rdata;
        nx = step(state_reg.c, state_reg.w, 1'b0);
        state_next.c    = nx[3:2];
        state_next.w    = nx[1:0];
        state_next.st   = nx[4] ? st_idle : st_rs_word;
        state_next.done = nx[4];
      end
    endcase

    // Count of lazy traps taken
    if (state_next.nm)
      state_next.nm_cnt = state_reg.nm_cnt + 16'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg      <= '0;
      state_reg.fen  <= FEAT_EN_RESET;
      state_reg.st   <= st_idle;
    end
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata                = state_reg.rdata;
  assign instr_ready              = (state_reg.st == st_idle);
  assign instr_done               = state_reg.done;
  assign res_a                    = state_reg.ra;
  assign res_b                    = state_reg.rb;
  assign res_c                    = state_reg.rc;
  assign res_d                    = state_reg.rd;
  assign device_unavailable_fault = state_reg.nm;
  assign privilege_fault          = state_reg.gp;
  assign invalid_opcode_fault     = state_reg.ud;
  assign lazy_trap_flag           = state_reg.lazy;
  assign mem_addr                 = state_reg.maddr;
  assign mem_wdata                = state_reg.mwdata;
  assign mem_wr                   = state_reg.mwr;
  assign mem_rd                   = state_reg.mrd;

endmodule // extended_state_save_control

`default_nettype wire

// ### sim/esc_sva.sv
// Port assertions for the extended state save control block
`timescale 1ns/10ps
`default_nettype none

module esc_sva
  import ext_state_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         reg_wr,
  input wire logic         instr_valid,
  input wire instr_class_e instr_class,
  input wire logic [1:0]   instr_ring,
  input wire logic [63:0]  instr_data,
  input wire logic [31:0]  instr_eax,
  input wire logic         instr_ready,
  input wire logic         instr_done,
  input wire logic [31:0]  res_c,
  input wire logic         device_unavailable_fault,
  input wire logic         privilege_fault,
  input wire logic         invalid_opcode_fault,
  input wire logic         lazy_trap_flag,
  input wire logic         mem_wr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction taken with no register write beside it
  logic tk;
  assign tk = instr_valid && instr_ready && !reg_wr;

  ////////////////////////////////////////////////////////////////////////////////
  // Trap, flag, query and save engine behaviour
  a_fp_traps: assert property (tk && lazy_trap_flag &&
    instr_class inside {ic_fp, ic_vector} |=> device_unavailable_fault && !instr_done)
    else $error("State access was not trapped");
  a_general_free: assert property (tk &&
    instr_class inside {ic_general, ic_checksum, ic_popcount} |=> instr_done && !device_unavailable_fault)
    else $error("General instruction trapped or did not finish");
  a_mov_sets: assert property (tk && instr_class == ic_mov_ctrl && instr_ring == 2'h0
    |=> lazy_trap_flag == $past(instr_data[3]))
    else $error("Control move did not load the flag");
  a_switch_sets: assert property (tk && instr_class == ic_task_switch |=> lazy_trap_flag)
    else $error("Task switch did not set the flag");
  a_clear_flag: assert property (tk && instr_class == ic_trap_clear && instr_ring == 2'h0
    |=> !lazy_trap_flag)
    else $error("Flag clear did not clear");
  a_feat_priv: assert property (tk && instr_class == ic_feat_write && instr_ring != 2'h0
    |=> (privilege_fault || invalid_opcode_fault) && !instr_done)
    else $error("Feature write outside ring zero not refused");
  a_basic_leaf: assert property (tk && instr_class == ic_query && instr_eax == LEAF_BASIC
    |=> instr_done && res_c[QUERY_XSUP_BIT])
    else $error("Basic leaf lacks save support bit");
  a_save_ends: assert property (tk && instr_class == ic_save |-> ##[1:60]
    (instr_done || device_unavailable_fault || privilege_fault || invalid_opcode_fault))
    else $error("Save did not finish in time");
  a_busy_mem: assert property (mem_wr |-> $past(!instr_ready))
    else $error("Engine ready during memory write");

  ////////////////////////////////////////////////////////////////////////////////
  // Main scenarios reached
  c_save: cover property (tk && instr_class == ic_save);
  c_restore: cover property (tk && instr_class == ic_restore);
  c_trap: cover property (device_unavailable_fault);
endmodule // esc_sva
`default_nettype wire

// ### sim/save_area_mem.sv
// Memory model holding the save areas seen by the control block
`timescale 1ns/10ps
`default_nettype none

module save_area_mem
(
  input  wire logic        clk,
  input  wire logic [31:0] mem_addr,
  input  wire logic [63:0] mem_wdata,
  input  wire logic        mem_wr,
  input  wire logic        mem_rd,
  output logic      [63:0] mem_rdata
);
  logic [63:0] mem [0:255];

  // Start with an empty area and quiet read data
  initial
  begin
    foreach (mem[i]) mem[i] = 64'h0;
    mem_rdata = 64'h0;
  end

  // Read data stands one cycle, then turns to its inverse
  always @(posedge clk)
  begin
    if (mem_wr) mem[mem_addr[10:3]] <= mem_wdata;
    if (mem_rd) mem_rdata <= mem[mem_addr[10:3]];
    else mem_rdata <= ~mem_rdata;
  end
endmodule // save_area_mem
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the extended state save control block
`timescale 1ns/10ps
`default_nettype none

module tb;
  import ext_state_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   reg_addr = 8'h00;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic         instr_valid = 1'b0;
  instr_class_e instr_class = ic_general;
  logic [1:0]   instr_ring = 2'h0;
  logic [63:0]  instr_data = 64'h0;
  logic [31:0]  instr_eax = 32'h0;
  logic [31:0]  instr_edx = 32'h0;
  logic [31:0]  instr_ecx = 32'h0;
  logic [31:0]  reg_rdata, res_a, res_b, res_c, res_d, mem_addr;
  logic         instr_ready, instr_done, lazy_trap_flag, mem_wr, mem_rd;
  logic         device_unavailable_fault, privilege_fault, invalid_opcode_fault;
  logic [63:0]  mem_wdata, mem_rdata;
  logic [3:0]   ev;
  int           err_total = 0;
  int           checks_done = 0;
  instr_class_e gen_q [3] = '{ic_general, ic_checksum, ic_popcount};

  extended_state_save_control i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .instr_valid, .instr_class, .instr_ring, .instr_data, .instr_eax, .instr_edx,
    .instr_ecx, .instr_ready, .instr_done, .res_a, .res_b, .res_c, .res_d,
    .device_unavailable_fault, .privilege_fault, .invalid_opcode_fault, .lazy_trap_flag,
    .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata);
  save_area_mem i_mem (.clk, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata);

  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus and instruction tasks
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // Issue one instruction; ev gets {done, unavailable, privilege, invalid}
  task automatic ins(input instr_class_e c, input logic [1:0] r, input logic [63:0] d,
                     input logic [31:0] a);
    @(posedge clk);
    instr_class <= c;
    instr_ring <= r;
    instr_data <= d;
    instr_eax <= a;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    ev = 4'h0;
    for (int i = 0; i < 100 && ev == 4'h0; i++)
    begin
      #1;
      ev = {instr_done, device_unavailable_fault, privilege_fault, invalid_opcode_fault};
      if (ev == 4'h0) @(posedge clk);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #100000;
    err_total++;
    end_sim;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(PRIMARY_CTRL_OFS, 32'h0);
    rd(FEAT_EN_LO_OFS, 32'h1);
    rd(8'h20, 32'h0);
    // Untrapped task loads state words
    ins(ic_fp, 2'h0, 64'h0123_4567_89ab_cdef, 32'h0);
    chk(ev, 4'h8);
    chk({res_b, res_a}, 64'h0);
    ins(ic_vector, 2'h0, 64'h1111_2222_3333_4444, 32'h0);
    chk(ev, 4'h8);
    // Flag set by control move, state access traps, general ops run
    ins(ic_mov_ctrl, 2'h0, 64'h8, 32'h0);
    rd(PRIMARY_CTRL_OFS, 32'h8);
    ins(ic_fp, 2'h0, 64'h0, 32'h0);
    chk(ev, 4'h4);
    foreach (gen_q[k])
    begin
      ins(gen_q[k], 2'h0, 64'h0, 32'h0);
      chk(ev, 4'h8);
    end
    rd(NM_COUNT_OFS, 32'h1);
    ins(ic_trap_clear, 2'h0, 64'h0, 32'h0);
    chk(lazy_trap_flag, 1'b0);
    ins(ic_task_switch, 2'h0, 64'h0, 32'h0);
    chk(lazy_trap_flag, 1'b1);
    ins(ic_trap_clear, 2'h0, 64'h0, 32'h0);
    // Extended state enable and enumeration
    ins(ic_feat_read, 2'h0, 64'h0, 32'h0);
    chk(ev, 4'h1);
    ins(ic_query, 2'h0, 64'h0, LEAF_BASIC);
    chk(res_c[27:26], 2'h1);
    wr(FOURTH_CTRL_OFS, 32'h0004_0000);
    ins(ic_query, 2'h0, 64'h0, LEAF_BASIC);
    chk(res_c[27:26], 2'h3);
    ins(ic_query, 2'h0, 64'h0, LEAF_XSTATE);
    chk(res_a, 32'h7);
    chk({res_b, res_c}, {32'h240, 32'h260});
    chk(res_d, 32'h0);
    ins(ic_feat_write, 2'h3, 64'h0, 32'h7);
    chk(ev, 4'h2);
    ins(ic_feat_write, 2'h0, 64'h0, 32'h6);
    chk(ev, 4'h2);
    ins(ic_feat_write, 2'h0, 64'h0, 32'h3);
    rd(FEAT_EN_LO_OFS, 32'h3);
    ins(ic_feat_read, 2'h3, 64'h0, 32'h0);
    chk({ev, res_a}, {4'h8, 32'h3});
    // Save keeps an old header bit and clears the zero words
    i_mem.mem[8'h40] = 64'h4;
    i_mem.mem[8'h41] = '1;
    i_mem.mem[8'h42] = '1;
    ins(ic_save, 2'h0, 64'h1000, 32'h3);
    chk(ev, 4'h8);
    // Last header word lands one edge after done
    @(posedge clk);
    #1;
    chk(i_mem.mem[8'h04], 64'h0123_4567_89ab_cdef);
    chk(i_mem.mem[8'h14], 64'h1111_2222_3333_4444);
    chk(i_mem.mem[8'h40], 64'h7);
    chk(i_mem.mem[8'h41] | i_mem.mem[8'h42], 64'h0);
    // Edited image flagged in header; restore only the first component
    i_mem.mem[8'h04] = 64'hfeed_0000_0000_0001;
    i_mem.mem[8'h14] = 64'h5555_5555_5555_5555;
    i_mem.mem[8'h40] = 64'h3;
    ins(ic_restore, 2'h0, 64'h1000, 32'h1);
    chk(ev, 4'h8);
    ins(ic_vector, 2'h0, 64'h9, 32'h0);
    chk({res_b, res_a}, 64'h1111_2222_3333_4444);
    ins(ic_fp, 2'h0, 64'h0, 32'h0);
    chk({res_b, res_a}, 64'hfeed_0000_0000_0001);
    // Clear header bit initialises despite stale region
    i_mem.mem[8'h40] = 64'h1;
    ins(ic_restore, 2'h0, 64'h1000, 32'h2);
    chk(ev, 4'h8);
    ins(ic_vector, 2'h0, 64'h0, 32'h0);
    chk({res_b, res_a}, 64'h0);
    // Misaligned area, then save under a set flag
    ins(ic_save, 2'h0, 64'h1010, 32'h1);
    chk(ev, 4'h2);
    ins(ic_task_switch, 2'h0, 64'h0, 32'h0);
    ins(ic_save, 2'h0, 64'h1000, 32'h1);
    chk(ev, 4'h4);
    end_sim;
  end
endmodule // tb

bind extended_state_save_control esc_sva i_sva (.clk, .rst, .reg_wr, .instr_valid, .instr_class,
  .instr_ring, .instr_data, .instr_eax, .instr_ready, .instr_done, .res_c,
  .device_unavailable_fault, .privilege_fault, .invalid_opcode_fault, .lazy_trap_flag, .mem_wr);
`default_nettype wire
